// [logic/epdsp_params.svh]
// timing counts, bit counts and reset values of the serial host port
// assumes the block clock runs at EPDSP_CLK_KHZ
`ifndef EPDSP_PARAMS_SVH
`define EPDSP_PARAMS_SVH

`define EPDSP_CLK_KHZ 100000
`define EPDSP_WR_FMAX_KHZ 20000
`define EPDSP_RD_FMAX_KHZ 2500
`define EPDSP_WR_HALF ((`EPDSP_CLK_KHZ + 2 * `EPDSP_WR_FMAX_KHZ - 1) / (2 * `EPDSP_WR_FMAX_KHZ))
`define EPDSP_RD_HALF ((`EPDSP_CLK_KHZ + 2 * `EPDSP_RD_FMAX_KHZ - 1) / (2 * `EPDSP_RD_FMAX_KHZ))
`define EPDSP_CSSU_NS 100
`define EPDSP_CSHLD_NS 50
`define EPDSP_CSHIGH_NS 250
`define EPDSP_NS2CYC(ns) (((ns) * `EPDSP_CLK_KHZ + 999999) / 1000000)
`define EPDSP_CSSU_CYC `EPDSP_NS2CYC(`EPDSP_CSSU_NS)
`define EPDSP_CSHLD_CYC `EPDSP_NS2CYC(`EPDSP_CSHLD_NS)
`define EPDSP_CSHIGH_CYC `EPDSP_NS2CYC(`EPDSP_CSHIGH_NS)
`define EPDSP_LAST_4W 4'h7
`define EPDSP_LAST_3W 4'h8
`define EPDSP_BITS_4W 4'h8
`define EPDSP_BITS_3W 4'h9
`define EPDSP_FLAG_BIT_3W 4'h1
`define EPDSP_CNT_RST 4'h0
`define EPDSP_BYTE_RST 8'h00

`endif

// [logic/epdsp_pkg.sv]
// mode type shared by both ends of the serial host port, and the state encoding of the host end
// assumes nothing of its surroundings
`default_nettype none
package epdsp_pkg;
	typedef enum logic {
		EPDSP_MODE_4WIRE = 1'b0,
		EPDSP_MODE_3WIRE = 1'b1
	} epdsp_mode_t;

	typedef enum logic [5:0] {
		H_IDLE = 6'b00_0001,
		H_SETUP = 6'b00_0010,
		H_LOW = 6'b00_0100,
		H_HIGH = 6'b00_1000,
		H_HOLD = 6'b01_0000,
		H_GAP = 6'b10_0000
	} epdsp_hstate_t;
endpackage : epdsp_pkg
`default_nettype wire

// [logic/epdsp_if.sv]
// link wires between host and display driver serial port
// assumes the bench joins both ends through one instance
`default_nettype none
interface epdsp_if;
	logic sclk;
	logic cs_n;
	logic dc_sel;
	logic serial_in;
	logic serial_out;
	logic busy;
	logic hw_reset_n;

	modport dev (
		input sclk,
		input cs_n,
		input dc_sel,
		input serial_in,
		input hw_reset_n,
		output serial_out,
		output busy
	);

	modport host (
		output sclk,
		output cs_n,
		output dc_sel,
		output serial_in,
		output hw_reset_n,
		input serial_out,
		input busy
	);
endinterface : epdsp_if
`default_nettype wire

// [logic/epdsp_sync.sv]
// two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent level from outside the clock domain
`default_nettype none
module epdsp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : epdsp_sync
`default_nettype wire

// [logic/epdsp_device.sv]
// display driver end of the serial host port
// assumes link pins arrive asynchronously; ref_clk well above serial clock
`include "epdsp_params.svh"
`default_nettype none
module epdsp_device (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic interface_select,
	epdsp_if.dev link,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_is_data,
	output logic rx_abort,
	input wire logic [7:0] rd_data,
	output logic rd_taken,
	input wire logic busy_req,
	output epdsp_pkg::epdsp_mode_t mode
);
	import epdsp_pkg::*;

	logic [5:0] pin_s;
	logic sclk_s;
	logic cs_n_s;
	logic dc_s;
	logic sin_s;
	logic hwrst_n_s;
	logic strap_s;
	logic rst;
	logic sclk_d;
	logic cs_n_d;
	logic rise;
	logic fall;
	logic active;
	logic [3:0] bit_cnt;
	logic [7:0] rx_shift;
	logic flag;
	logic [7:0] tx_shift;
	logic serial_out;
	logic load;
	logic shift;

	// last bit position of a word in the given format
	function automatic logic word_end(epdsp_mode_t m, logic [3:0] cnt);
		if (m == EPDSP_MODE_3WIRE) begin
			return cnt == `EPDSP_LAST_3W;
		end
		return cnt == `EPDSP_LAST_4W;
	endfunction : word_end

	epdsp_sync #(
		.W(6),
		.RST_VAL(6'b11_0000)
	) u_pins (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d({link.sclk, link.cs_n, link.dc_sel, link.serial_in,
			link.hw_reset_n, interface_select}),
		.q(pin_s)
	);

	assign sclk_s = pin_s[5];
	assign cs_n_s = pin_s[4];
	assign dc_s = pin_s[3];
	assign sin_s = pin_s[2];
	assign hwrst_n_s = pin_s[1];
	assign strap_s = pin_s[0];

	// the reset pin acts like the block reset, still on the clock
	assign rst = !nrst || !hwrst_n_s;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	assign active = !cs_n_s;
	assign rise = active && sclk_s && !sclk_d;
	assign fall = active && !sclk_s && sclk_d;

	// format follows the strap, changed only between transfers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode <= EPDSP_MODE_4WIRE;
		end else if (cs_n_s) begin
			mode <= epdsp_mode_t'(strap_s);
		end
	end

	// bit position within the current word
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_s) begin
			bit_cnt <= `EPDSP_CNT_RST;
		end else if (rise) begin
			if (word_end(mode, bit_cnt)) begin
				bit_cnt <= `EPDSP_CNT_RST;
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
			end
		end
	end

	// incoming bits, msb first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_shift <= `EPDSP_BYTE_RST;
		end else if (rise) begin
			rx_shift <= {rx_shift[6:0], sin_s};
		end
	end

	// leading command/data flag of a nine-bit word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (rise && mode == EPDSP_MODE_3WIRE
			&& bit_cnt == `EPDSP_CNT_RST) begin
			flag <= sin_s;
		end
	end

	// hand each finished word to the core
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_valid <= 1'b0;
			rx_byte <= `EPDSP_BYTE_RST;
			rx_is_data <= 1'b0;
		end else begin
			rx_valid <= rise && word_end(mode, bit_cnt);
			if (rise && word_end(mode, bit_cnt)) begin
				rx_byte <= {rx_shift[6:0], sin_s};
				if (mode == EPDSP_MODE_3WIRE) begin
					rx_is_data <= flag;
				end else begin
					rx_is_data <= dc_s;
				end
			end
		end
	end

	// a word cut short by chip select is reported and dropped
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_abort <= 1'b0;
		end else begin
			rx_abort <= cs_n_s && !cs_n_d
				&& bit_cnt != `EPDSP_CNT_RST;
		end
	end

	// read data: first bit goes out on the falling edge that opens a data
	// byte in four-wire, or the one after the flag in three-wire
	always_comb begin
		if (mode == EPDSP_MODE_3WIRE) begin
			load = fall && flag && bit_cnt == `EPDSP_FLAG_BIT_3W;
			shift = fall && bit_cnt > `EPDSP_FLAG_BIT_3W;
		end else begin
			load = fall && dc_s && bit_cnt == `EPDSP_CNT_RST;
			shift = fall && bit_cnt != `EPDSP_CNT_RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_s) begin
			tx_shift <= `EPDSP_BYTE_RST;
			serial_out <= 1'b0;
		end else if (load) begin
			serial_out <= rd_data[7];
			tx_shift <= {rd_data[6:0], 1'b0};
		end else if (shift) begin
			serial_out <= tx_shift[7];
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// tells the core the offered byte has been taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_taken <= 1'b0;
		end else begin
			rd_taken <= load;
		end
	end

	// busy is shown to the host while the core works
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			link.busy <= 1'b0;
		end else begin
			link.busy <= busy_req;
		end
	end

	assign link.serial_out = serial_out;
endmodule : epdsp_device
`default_nettype wire

// [logic/epdsp_host.sv]
// host microcontroller end of the serial host port, master of the link
// assumes link inputs arrive asynchronously; user side is on ref_clk
`include "epdsp_params.svh"
`default_nettype none
module epdsp_host (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic interface_select,
	epdsp_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_is_data,
	input wire logic cmd_read,
	input wire logic cmd_last,
	input wire logic reset_req,
	output logic rsp_valid,
	output logic [7:0] rsp_byte
);
	import epdsp_pkg::*;

	logic [2:0] pin_s;
	epdsp_mode_t mode;
	epdsp_hstate_t state;
	logic [5:0] timer;
	logic [5:0] half;
	logic [3:0] bits_left;
	logic [8:0] tx;
	logic [7:0] rx;
	logic reading;
	logic last;
	logic accept;

	epdsp_sync #(
		.W(3),
		.RST_VAL(3'b000)
	) u_pins (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d({link.serial_out, link.busy, interface_select}),
		.q(pin_s)
	);

	assign accept = cmd_valid && cmd_ready;
	assign half = reading ? 6'(`EPDSP_RD_HALF - 1)
		: 6'(`EPDSP_WR_HALF - 1);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mode <= EPDSP_MODE_4WIRE;
		end else if (state == H_IDLE && link.cs_n) begin
			mode <= epdsp_mode_t'(pin_s[0]);
		end
	end

	// no new word while the device is busy
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= state == H_IDLE && !accept && !pin_s[1];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			link.hw_reset_n <= 1'b0;
		end else begin
			link.hw_reset_n <= !reset_req;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= H_IDLE;
			timer <= 6'h00;
			bits_left <= 4'h0;
			tx <= 9'h000;
			rx <= `EPDSP_BYTE_RST;
			reading <= 1'b0;
			last <= 1'b0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.dc_sel <= 1'b0;
			link.serial_in <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_byte <= `EPDSP_BYTE_RST;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state)
			H_IDLE: begin
				if (accept) begin
					reading <= cmd_read && cmd_is_data;
					last <= cmd_last;
					if (mode == EPDSP_MODE_3WIRE) begin
						tx <= {cmd_is_data, cmd_byte};
						link.serial_in <= cmd_is_data;
						link.dc_sel <= 1'b0;
						bits_left <= `EPDSP_BITS_3W;
					end else begin
						tx <= {cmd_byte, 1'b0};
						link.serial_in <= cmd_byte[7];
						link.dc_sel <= cmd_is_data;
						bits_left <= `EPDSP_BITS_4W;
					end
					link.sclk <= 1'b0;
					if (link.cs_n) begin
						link.cs_n <= 1'b0;
						timer <= 6'(`EPDSP_CSSU_CYC - 1);
						state <= H_SETUP;
					end else begin
						timer <= (cmd_read && cmd_is_data)
							? 6'(`EPDSP_RD_HALF - 1)
							: 6'(`EPDSP_WR_HALF - 1);
						state <= H_LOW;
					end
				end
			end
			H_SETUP: begin
				if (timer == 6'h00) begin
					timer <= half;
					state <= H_LOW;
				end else begin
					timer <= timer - 6'h01;
				end
			end
			H_LOW: begin
				if (timer == 6'h00) begin
					link.sclk <= 1'b1;
					timer <= half;
					state <= H_HIGH;
					if (reading && !(mode == EPDSP_MODE_3WIRE
						&& bits_left == `EPDSP_BITS_3W)) begin
						rx <= {rx[6:0], pin_s[2]};
					end
				end else begin
					timer <= timer - 6'h01;
				end
			end
			H_HIGH: begin
				if (timer != 6'h00) begin
					timer <= timer - 6'h01;
				end else if (bits_left == 4'h1) begin
					rsp_valid <= reading;
					rsp_byte <= rx;
					timer <= 6'(`EPDSP_CSHLD_CYC - 1);
					state <= last ? H_HOLD : H_IDLE;
				end else begin
					bits_left <= bits_left - 4'h1;
					tx <= {tx[7:0], 1'b0};
					link.serial_in <= tx[7];
					link.sclk <= 1'b0;
					timer <= half;
					state <= H_LOW;
				end
			end
			H_HOLD: begin
				if (timer == 6'h00) begin
					link.cs_n <= 1'b1;
					timer <= 6'(`EPDSP_CSHIGH_CYC - 1);
					state <= H_GAP;
				end else begin
					timer <= timer - 6'h01;
				end
			end
			H_GAP: begin
				if (timer == 6'h00) begin
					link.sclk <= 1'b0;
					link.dc_sel <= 1'b0;
					state <= H_IDLE;
				end else begin
					timer <= timer - 6'h01;
				end
			end
			default: begin
				state <= H_IDLE;
			end
			endcase
		end
	end
endmodule : epdsp_host
`default_nettype wire

// [test/epdsp_props.sv]
// link checker: timing and framing relations on the host port wires
// assumes one epdsp_if joins the two ends, both ends on ref_clk
`default_nettype none
module epdsp_props (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dc_sel,
	input wire logic serial_out,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence clk_high; sclk [*3]; endsequence
	sequence clk_low; !sclk [*3]; endsequence
	deselect_quiet_a: assert property (
		cs_n |-> !$rose(sclk)) else $error("clock rose while deselected");
	select_steady_a: assert property (
		!cs_n && !$past(cs_n) && $changed(dc_sel) |-> $fell(sclk))
		else $error("select changed inside a byte");
	busy_blocks_a: assert property (
		(busy && cs_n) [*5] |=> cs_n) else $error("frame began while busy");
	high_half_a: assert property (
		$rose(sclk) |-> clk_high) else $error("clock high half too short");
	low_half_a: assert property (
		$fell(sclk) |-> clk_low) else $error("clock low half too short");
	select_setup_a: assert property (
		$fell(cs_n) |=> !$rose(sclk) [*8]) else $error("select setup short");
	deselect_gap_a: assert property (
		$rose(cs_n) |-> cs_n [*8]) else $error("deselect gap too short");
	out_on_fall_a: assert property (
		!cs_n && $changed(serial_out) |-> !$past(sclk, 2))
		else $error("output changed away from a falling edge");
endmodule : epdsp_props
`default_nettype wire

// [test/testbench.sv]
// self-checking bench: host and device ends joined over the link
// assumes design files and the link checker are compiled before it
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin \
	fails++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
`define WT(s) begin n = 0; while ((s) !== 1'b1 && n++ < 3000) \
	@(negedge ref_clk); if (n > 3000) fails++; end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import epdsp_pkg::*;
	logic ref_clk = 0, nrst = 0, strap = 0, busy_req = 0;
	logic cmd_valid = 0, cmd_is_data = 0, cmd_read = 0, cmd_last = 0;
	logic [7:0] cmd_byte = '0, rd_data = '0, rsp_byte, rx_byte, r2_byte;
	logic cmd_ready, rsp_valid, rx_valid, rx_is_data, r2_valid, r2_abort;
	logic reset_req = 0, r1_abort, rd_taken;
	logic [8:0] sh;
	logic [7:0] so;
	int fails = 0, check_count = 0, cyc = 0, seed = 47059, n2v, n2a;
	int n1a = 0, nt = 0;
	epdsp_mode_t mode;
	epdsp_if lk ();
	epdsp_if lk2 ();
	epdsp_host epdsp_host_i (.ref_clk, .nrst, .interface_select(strap),
		.link(lk), .cmd_valid, .cmd_ready, .cmd_byte, .cmd_is_data,
		.cmd_read, .cmd_last, .reset_req, .rsp_valid, .rsp_byte);
	epdsp_device epdsp_device_i (.ref_clk, .nrst, .interface_select(strap),
		.link(lk), .rx_valid, .rx_byte, .rx_is_data, .rx_abort(r1_abort),
		.rd_data, .rd_taken, .busy_req, .mode);
	epdsp_device epdsp_device_i2 (.ref_clk, .nrst, .interface_select(strap),
		.link(lk2), .rx_valid(r2_valid), .rx_byte(r2_byte), .rx_is_data(),
		.rx_abort(r2_abort), .rd_data, .rd_taken(), .busy_req(1'b0),
		.mode());
	epdsp_props epdsp_props_i (.ref_clk, .nrst, .sclk(lk.sclk),
		.cs_n(lk.cs_n), .dc_sel(lk.dc_sel), .serial_out(lk.serial_out),
		.busy(lk.busy));
	initial begin
		{lk2.cs_n, lk2.hw_reset_n} = 2'b11;
		{lk2.sclk, lk2.dc_sel, lk2.serial_in} = 3'b000;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge lk.sclk) if (!lk.cs_n) begin
		sh <= {sh[7:0], lk.serial_in};
		so <= {so[6:0], lk.serial_out};
	end
	always @(posedge ref_clk) begin
		n2v += (r2_valid === 1'b1);
		n2a += (r2_abort === 1'b1);
		n1a += (r1_abort === 1'b1);
		nt += (rd_taken === 1'b1);
		if (++cyc == 60000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// word as it must appear on the data pin for the current format
	function automatic logic [8:0] exp_word(input logic d,
		input logic [7:0] b);
		return strap ? {d, b} : {1'b0, b};
	endfunction : exp_word
	task automatic send(input logic [7:0] b, input logic d, rd, last);
		int n, t0;
		@(negedge ref_clk);
		t0 = nt;
		{cmd_valid, cmd_byte, cmd_is_data, cmd_read, cmd_last} =
			{1'b1, b, d, rd, last};
		`WT(cmd_ready)
		@(negedge ref_clk);
		cmd_valid = 0;
		`WT(rx_valid)
		`CHK("rx_byte", rx_byte, b)
		`CHK("rx_is_data", rx_is_data, d)
		if (strap)
			`CHK("dc_sel", lk.dc_sel, 1'b0)
		if (!rd)
			`CHK("wire", strap ? sh : {1'b0, sh[7:0]}, exp_word(d, b))
		else begin
			`WT(rsp_valid)
			`CHK("rsp_byte", rsp_byte, rd_data)
			`CHK("serial_out", so, rd_data)
		end
		`CHK("rd_taken", nt - t0, int'(d))
	endtask : send
	task automatic bang(input int nb, input logic [8:0] w, input logic hi);
		lk2.cs_n = hi;
		for (int i = nb - 1; i >= 0; i--) begin
			repeat (8) @(negedge ref_clk);
			{lk2.sclk, lk2.serial_in} = {1'b0, w[i]};
			repeat (8) @(negedge ref_clk);
			lk2.sclk = 1;
		end
		repeat (8) @(negedge ref_clk);
		{lk2.cs_n, lk2.serial_in} = {1'b1, ~lk2.serial_in};
		repeat (30) @(negedge ref_clk);
	endtask : bang
	initial begin
		repeat (2) @(negedge ref_clk);
		nrst = 1;
		for (int m = 0; m < 2; m++) begin
			strap = m[0];
			repeat (8) @(negedge ref_clk);
			`CHK("mode", mode, epdsp_mode_t'(m[0]))
			send(8'h80, 0, 0, 0);
			send(8'h01, 1, 0, 0);
			send(8'h00, 1, 0, 0);
			send(8'($random(seed)), 1, 0, 1);
			send(8'hFF, 0, 0, 0);
			for (int i = 0; i < 2; i++) begin
				rd_data = 8'($random(seed));
				send(8'($random(seed)), 1, 1, i == 1);
			end
			busy_req = 1;
			fork
				send(8'h12, 0, 0, 1);
				begin
					repeat (40) @(negedge ref_clk);
					`CHK("cs_n", lk.cs_n, 1'b1)
					busy_req = 0;
				end
			join
			n2v = 0;
			n2a = 0;
			bang(5, 9'h1AA, 0);
			`CHK("aborts", n2a, 1)
			bang(9, 9'h0C3, 1);
			`CHK("words", n2v, 0)
			bang(m ? 9 : 8, 9'h0C3, 0);
			`CHK("words", n2v, 1)
			`CHK("r2_byte", r2_byte, 8'hC3)
			reset_req = 1;
			repeat (6) @(negedge ref_clk);
			`CHK("hw_reset_n", lk.hw_reset_n, 1'b0)
			`CHK("mode", mode, EPDSP_MODE_4WIRE)
			reset_req = 0;
			repeat (8) @(negedge ref_clk);
			`CHK("hw_reset_n", lk.hw_reset_n, 1'b1)
			`CHK("mode", mode, epdsp_mode_t'(m[0]))
			`CHK("host aborts", n1a, 0)
			$display("mode %0d done", m);
		end
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
